// [cwr_pkg.sv]
// Purpose: Shared constants for the charger watchdog reset supervisor
// Assumes: 125 MHz system clock, AXI4-Lite register access
// Notes:   Offsets are byte addresses of aligned 32-bit words
package cwr_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ              = 125_000_000;
    localparam int unsigned MS_PER_S            = 1000;
    localparam int unsigned US_PER_S            = 1_000_000;
    localparam int unsigned MS_TICK_CYCLES      = CLK_HZ / MS_PER_S;
    localparam int unsigned EXT_RST_HOLD_US     = 100;
    localparam int unsigned EXT_RST_HOLD_CYCLES = (EXT_RST_HOLD_US * (CLK_HZ / US_PER_S));
    localparam int unsigned POR_PULSE_DEF       = 16;
    localparam logic [15:0] WDT_TIMEOUT_MS      = 16'h07d0;   // Two seconds

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int          ADDR_W     = 4;
    localparam logic [3:0]  OFS_CTRL   = 4'h0;
    localparam logic [3:0]  OFS_STATUS = 4'h4;
    localparam logic [3:0]  OFS_TMO    = 4'h8;
    localparam int          CTRL_EN    = 0;
    localparam int          CTRL_STOP  = 1;
    localparam int          ST_EN      = 0;
    localparam int          ST_RUN     = 1;
    localparam int          ST_CHG     = 2;
    localparam int          ST_TM_LO   = 3;
    localparam int          ST_REM_LO  = 16;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // Pin pull states while the chip is held in reset
    // ----------------------------------------------------------------
    localparam int          GPIO_N         = 14;
    localparam logic [13:0] PULL_UP_MASK   = 14'h08f8;
    localparam logic [13:0] PULL_DOWN_MASK = 14'h3707;

    // ----------------------------------------------------------------
    // Test strap modes
    // ----------------------------------------------------------------
    localparam logic [1:0]  TM_NORMAL   = 2'h0;
    localparam logic [1:0]  TM_SCAN     = 2'h1;
    localparam logic [1:0]  TM_RESERVED = 2'h2;

    typedef enum logic [0:0] {WD_IDLE, WD_RUN} cwr_wd_state_t;

    // High strap wins; the low strap alone selects scan debug
    function automatic logic [1:0] cwr_strap_decode(input logic lo, input logic hi);
        logic [1:0] m;
        m = TM_NORMAL;
        if (hi) begin
            m = TM_RESERVED;
        end else if (lo) begin
            m = TM_SCAN;
        end
        return m;
    endfunction

endpackage

// [cwr_sync.sv]
// Purpose: Two-flop synchroniser for a bundle of asynchronous levels
// Assumes: Each bit is independent; no multi-bit coherence needed
// Notes:   Reset value is per bit so idle levels do not glitch
`timescale 1ns/1ps
`default_nettype none
module cwr_sync #(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= RST_VAL;
            q_o  <= RST_VAL;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule
`default_nettype wire

// [cwr_rst_qual.sv]
// Purpose: Qualifies an external active-low reset by a minimum hold time
// Assumes: Input already synchronised to the clock
// Notes:   Output stays asserted for as long as the input stays low
`timescale 1ns/1ps
`default_nettype none
module cwr_rst_qual #(
    parameter int unsigned HOLD_CYCLES = 12500
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic ext_n_i,
    output logic      qual_o
);
    localparam int CW = $clog2(HOLD_CYCLES + 1);
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic          next_qual;

    if (HOLD_CYCLES < 1) begin : g_chk
        $error("HOLD_CYCLES must be at least one");
    end

    // Short glitches restart the count, so only a full hold resets the chip
    always_comb begin
        next_cnt  = cnt;
        next_qual = 1'b0;
        if (ext_n_i) begin
            next_cnt = '0;
        end else if (cnt != CW'(HOLD_CYCLES)) begin
            next_cnt = cnt + 1'b1;
        end else begin
            next_qual = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt    <= '0;
            qual_o <= 1'b0;
        end else begin
            cnt    <= next_cnt;
            qual_o <= next_qual;
        end
    end
endmodule
`default_nettype wire

// [cwr_top.sv]
// Purpose: Reset supervisor with charger-armed watchdog and strap decode
// Assumes: Firmware on AXI4-Lite; charger detect and pins are asynchronous
// Notes:   A chip reset pulse clears watchdog control but not charger history
//
// Summary of operation
// - Watchdog disabled after every power-on reset
// - Enable is sticky; writes cannot disable
// - Enabled watchdog starts counting on charger attach
// - Countdown runs to reset unless firmware stops
// - Stays inactive after reset or stop while attached
// - Rearm only on charger detach then attach
// - Timeout defaults to two seconds
// - External reset low forces power-on state
// - Pull pins up or down during reset
// - Decode test straps: normal, scan, reserved
`timescale 1ns/1ps
`default_nettype none
module cwr_top
    import cwr_pkg::*;
#(
    parameter int unsigned TICK_CYCLES      = MS_TICK_CYCLES,
    parameter int unsigned EXT_HOLD_CYCLES  = EXT_RST_HOLD_CYCLES,
    parameter int unsigned POR_PULSE_CYCLES = POR_PULSE_DEF
) (
    input  wire logic              SYS_CLK_I,
    input  wire logic              RST_N_I,
    input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
    input  wire logic              S_AXI_AWVALID_I,
    output logic                   S_AXI_AWREADY_O,
    input  wire logic [31:0]       S_AXI_WDATA_I,
    input  wire logic [3:0]        S_AXI_WSTRB_I,
    input  wire logic              S_AXI_WVALID_I,
    output logic                   S_AXI_WREADY_O,
    output logic [1:0]             S_AXI_BRESP_O,
    output logic                   S_AXI_BVALID_O,
    input  wire logic              S_AXI_BREADY_I,
    input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
    input  wire logic              S_AXI_ARVALID_I,
    output logic                   S_AXI_ARREADY_O,
    output logic [31:0]            S_AXI_RDATA_O,
    output logic [1:0]             S_AXI_RRESP_O,
    output logic                   S_AXI_RVALID_O,
    input  wire logic              S_AXI_RREADY_I,
    input  wire logic              CHARGER_PRESENT_I,
    input  wire logic              EXT_RST_N_I,
    input  wire logic              TEST_STRAP_LOW_BIT_I,
    input  wire logic              TEST_STRAP_HIGH_BIT_I,
    output logic                   CHIP_RST_N_O,
    output logic [GPIO_N-1:0]      GPIO_PULL_UP_O,
    output logic [GPIO_N-1:0]      GPIO_PULL_DOWN_O,
    output logic [1:0]             TEST_MODE_O
);
    localparam int TW = $clog2(TICK_CYCLES);
    localparam int PW = $clog2(POR_PULSE_CYCLES + 1);

    if (TICK_CYCLES < 2 || POR_PULSE_CYCLES < 1) begin : g_chk
        $error("TICK_CYCLES must be two or more and POR_PULSE_CYCLES one or more");
    end

    // ----------------------------------------------------------------
    // Pin synchronisation and external reset qualification
    // ----------------------------------------------------------------
    logic [3:0] pins_s;
    logic       ext_qual;

    cwr_sync #(.W(4), .RST_VAL(4'h2)) u_sync (
        .clk_i   (SYS_CLK_I),
        .rst_n_i (RST_N_I),
        .d_i     ({TEST_STRAP_HIGH_BIT_I, TEST_STRAP_LOW_BIT_I,
                   EXT_RST_N_I, CHARGER_PRESENT_I}),
        .q_o     (pins_s)
    );

    cwr_rst_qual #(.HOLD_CYCLES(EXT_HOLD_CYCLES)) u_qual (
        .clk_i   (SYS_CLK_I),
        .rst_n_i (RST_N_I),
        .ext_n_i (pins_s[1]),
        .qual_o  (ext_qual)
    );

    // ----------------------------------------------------------------
    // Bus slave state
    // ----------------------------------------------------------------
    logic              aw_have, w_have, next_aw_have, next_w_have;
    logic [ADDR_W-1:0] aw_addr, next_aw_addr, next_rd_addr;
    logic [31:0]       w_data, next_w_data, next_rdata;
    logic [3:0]        w_strb, next_w_strb;
    logic              next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0]        next_bresp, next_rresp;
    logic              wr_fire;

    // ----------------------------------------------------------------
    // Watchdog state
    // ----------------------------------------------------------------
    cwr_wd_state_t   state, next_state;
    logic            enable, next_enable;
    logic [15:0]     tmo, next_tmo, count, next_count;
    logic [TW-1:0]   tick_cnt, next_tick_cnt;
    logic [PW-1:0]   por_cnt, next_por_cnt;
    logic            chg_prev, next_chg_prev, primed, next_primed;
    logic            attach, detach, in_rst, stop_evt, expire;
    logic            next_chip_rst_n;

    assign in_rst = ext_qual || (por_cnt != '0);

    // Priming masks only the first cycle after release; the charger bit syncs from low, so a charger present at reset still gives one attach
    assign attach = primed && pins_s[0] && !chg_prev;
    assign detach = primed && !pins_s[0] && chg_prev;

    // Both address and data must be held before a write takes effect
    assign wr_fire  = aw_have && w_have && !S_AXI_BVALID_O;
    assign stop_evt = wr_fire && (aw_addr == OFS_CTRL) && w_strb[0] && w_data[CTRL_STOP];
    assign expire   = (state == WD_RUN) && (tick_cnt == TW'(TICK_CYCLES - 1))
                      && (count == 16'h0001) && !stop_evt;

    // Write path: channels are taken in any order, one response per write
    always_comb begin
        next_aw_have = aw_have;
        next_w_have  = w_have;
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = S_AXI_BVALID_O;
        next_bresp   = S_AXI_BRESP_O;
        if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
            next_aw_have = 1'b1;
            next_aw_addr = S_AXI_AWADDR_I;
        end
        if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
            next_w_have = 1'b1;
            next_w_data = S_AXI_WDATA_I;
            next_w_strb = S_AXI_WSTRB_I;
        end
        if (wr_fire) begin
            next_aw_have = 1'b0;
            next_w_have  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = (aw_addr == OFS_STATUS || aw_addr == OFS_CTRL
                            || aw_addr == OFS_TMO) ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
            next_bvalid = 1'b0;
        end
        next_awready = !next_aw_have && !next_bvalid;
        next_wready  = !next_w_have && !next_bvalid;
    end

    // Read path: one cycle from address taken to data valid
    always_comb begin
        next_arready = S_AXI_ARREADY_O;
        next_rvalid  = S_AXI_RVALID_O;
        next_rdata   = S_AXI_RDATA_O;
        next_rresp   = S_AXI_RRESP_O;
        next_rd_addr = S_AXI_ARADDR_I;
        if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
            next_arready = 1'b0;
            next_rvalid  = 1'b1;
            next_rresp   = RESP_OKAY;
            next_rdata   = '0;
            case (next_rd_addr)
                OFS_CTRL: begin
                    next_rdata[CTRL_EN] = enable;
                end
                OFS_STATUS: begin
                    next_rdata[ST_EN]              = enable;
                    next_rdata[ST_RUN]             = (state == WD_RUN);
                    next_rdata[ST_CHG]             = pins_s[0];
                    next_rdata[ST_TM_LO +: 2]      = TEST_MODE_O;
                    next_rdata[ST_REM_LO +: 16]    = count;
                end
                OFS_TMO: begin
                    next_rdata[15:0] = tmo;
                end
                default: begin
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
            next_rvalid  = 1'b0;
            next_arready = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            aw_have         <= 1'b0;
            w_have          <= 1'b0;
            aw_addr         <= '0;
            w_data          <= '0;
            w_strb          <= '0;
            S_AXI_AWREADY_O <= 1'b1;
            S_AXI_WREADY_O  <= 1'b1;
            S_AXI_BVALID_O  <= 1'b0;
            S_AXI_BRESP_O   <= RESP_OKAY;
            S_AXI_ARREADY_O <= 1'b1;
            S_AXI_RVALID_O  <= 1'b0;
            S_AXI_RDATA_O   <= '0;
            S_AXI_RRESP_O   <= RESP_OKAY;
        end else begin
            aw_have         <= next_aw_have;
            w_have          <= next_w_have;
            aw_addr         <= next_aw_addr;
            w_data          <= next_w_data;
            w_strb          <= next_w_strb;
            S_AXI_AWREADY_O <= next_awready;
            S_AXI_WREADY_O  <= next_wready;
            S_AXI_BVALID_O  <= next_bvalid;
            S_AXI_BRESP_O   <= next_bresp;
            S_AXI_ARREADY_O <= next_arready;
            S_AXI_RVALID_O  <= next_rvalid;
            S_AXI_RDATA_O   <= next_rdata;
            S_AXI_RRESP_O   <= next_rresp;
        end
    end

    // ----------------------------------------------------------------
    // Watchdog, chip reset and pin pulls
    // ----------------------------------------------------------------
    // Charger history survives the chip reset pulse, so a reset with the
    // charger still attached cannot produce a fresh attach and rearm
    always_comb begin
        next_state      = state;
        next_enable     = enable;
        next_tmo        = tmo;
        next_count      = count;
        next_tick_cnt   = tick_cnt;
        next_por_cnt    = (por_cnt != '0) ? por_cnt - 1'b1 : por_cnt;
        next_chg_prev   = pins_s[0];
        next_primed     = 1'b1;
        if (in_rst) begin
            next_state  = WD_IDLE;
            next_enable = 1'b0;
            next_tmo    = WDT_TIMEOUT_MS;
            next_count  = '0;
        end else begin
            if (wr_fire && aw_addr == OFS_CTRL && w_strb[0] && w_data[CTRL_EN]) begin
                next_enable = 1'b1;
            end
            if (wr_fire && aw_addr == OFS_TMO && w_strb[1:0] == 2'h3
                && w_data[15:0] != 16'h0000) begin
                next_tmo = w_data[15:0];
            end
            case (state)
                WD_IDLE: begin
                    if (attach && enable) begin
                        next_state    = WD_RUN;
                        next_count    = tmo;
                        next_tick_cnt = '0;
                    end
                end
                WD_RUN: begin
                    if (stop_evt || expire) begin
                        next_state = WD_IDLE;
                        next_count = '0;
                    end else if (tick_cnt == TW'(TICK_CYCLES - 1)) begin
                        next_tick_cnt = '0;
                        next_count    = count - 1'b1;
                    end else begin
                        next_tick_cnt = tick_cnt + 1'b1;
                    end
                end
                default: begin
                    next_state = WD_IDLE;
                end
            endcase
        end
        if (expire) begin
            next_por_cnt = PW'(POR_PULSE_CYCLES);
        end
        next_chip_rst_n = !(ext_qual || expire || next_por_cnt != '0);
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state            <= WD_IDLE;
            enable           <= 1'b0;
            tmo              <= WDT_TIMEOUT_MS;
            count            <= '0;
            tick_cnt         <= '0;
            por_cnt          <= '0;
            chg_prev         <= 1'b0;
            primed           <= 1'b0;
            CHIP_RST_N_O     <= 1'b0;
            GPIO_PULL_UP_O   <= PULL_UP_MASK;
            GPIO_PULL_DOWN_O <= PULL_DOWN_MASK;
            TEST_MODE_O      <= TM_NORMAL;
        end else begin
            state            <= next_state;
            enable           <= next_enable;
            tmo              <= next_tmo;
            count            <= next_count;
            tick_cnt         <= next_tick_cnt;
            por_cnt          <= next_por_cnt;
            chg_prev         <= next_chg_prev;
            primed           <= next_primed;
            CHIP_RST_N_O     <= next_chip_rst_n;
            GPIO_PULL_UP_O   <= next_chip_rst_n ? '0 : PULL_UP_MASK;
            GPIO_PULL_DOWN_O <= next_chip_rst_n ? '0 : PULL_DOWN_MASK;
            TEST_MODE_O      <= cwr_strap_decode(pins_s[2], pins_s[3]);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_N_I);

    a_off_after_reset: assert property ($rose(CHIP_RST_N_O) |-> !enable && state == WD_IDLE)
        else $error("Watchdog enabled on leaving reset");
    a_enable_sticky: assert property (enable && !in_rst |=> enable)
        else $error("Watchdog enable dropped without reset");
    a_arm_on_attach: assert property (attach && enable && state == WD_IDLE && !in_rst
        |=> state == WD_RUN && count == $past(tmo))
        else $error("Attach did not start countdown");
    a_run_continues: assert property (state == WD_RUN && !stop_evt && !expire && !in_rst
        |=> state == WD_RUN)
        else $error("Countdown left run state without cause");
    a_expire_resets: assert property (expire |=> !CHIP_RST_N_O ##1 in_rst)
        else $error("Expiry did not reset chip");
    a_no_rearm: assert property (state == WD_IDLE && !attach |=> state == WD_IDLE)
        else $error("Watchdog restarted without attach");
    a_default_tmo: assert property ($rose(CHIP_RST_N_O) |-> tmo == WDT_TIMEOUT_MS)
        else $error("Timeout not at default after reset");
    a_ext_reset: assert property (ext_qual |=> !CHIP_RST_N_O && !enable)
        else $error("External reset did not force reset state");
    a_pull_states: assert property (!CHIP_RST_N_O |-> GPIO_PULL_UP_O == PULL_UP_MASK
        && GPIO_PULL_DOWN_O == PULL_DOWN_MASK)
        else $error("Pin pulls wrong during reset");
    a_strap_decode: assert property (pins_s[3] |=> TEST_MODE_O == TM_RESERVED)
        else $error("High strap did not select reserved mode");
    a_attach_pulse: assert property (attach |=> !attach ##1 !attach)
        else $error("Attach event lasted more than one cycle");

endmodule
`default_nettype wire

// [cwr_far.sv]
// Purpose: Far-side model: charger detect line and external reset source
// Assumes: Bench calls the tasks at a rising clock edge
// Notes:   Charger detect is a driven level with no released state
`timescale 1ns/1ps
`default_nettype none
module cwr_far (
    input  wire logic clk_i,
    output logic      chg_o,
    output logic      ext_n_o
);
    // Idle: no charger, reset source released
    initial begin
        chg_o = 1'b0;
        ext_n_o = 1'b1;
    end
    // Attach or detach the charger just after an edge
    task automatic plug(input logic v);
        @(posedge clk_i);
        chg_o <= v;
    endtask
    // Short pulses probe the hold filter, long ones must reset the chip
    task automatic ext_low(input int n);
        @(posedge clk_i);
        ext_n_o <= 1'b0;
        repeat (n) @(posedge clk_i);
        ext_n_o <= 1'b1;
    endtask
endmodule
`default_nettype wire

// [charger_watchdog_reset_supervisor_test.sv]
// Purpose: Self-checking bench for the charger watchdog reset supervisor
// Assumes: Short tick and hold parameters keep the run brief
// Notes:   Expected state is kept in m_en and m_tmo, never read back
`timescale 1ns/1ps
`default_nettype none
module charger_watchdog_reset_supervisor_test;
    import cwr_pkg::*;
    localparam int TK = 4;
    logic        clk, rst_n, awv, wv, br, arv, rr, lo, hi;
    logic [3:0]  awa, ara, ws;
    logic [31:0] wd, rd;
    wire logic   awr, wr_r, bv, arr, rv, chg, ext_n, chip_n;
    wire logic [1:0]  bresp, rresp, tm;
    wire logic [31:0] rdata;
    wire logic [13:0] pu, pd;
    int          n_errors, compares, tmo, n, m_en, m_tmo;

    cwr_top #(.TICK_CYCLES(TK), .EXT_HOLD_CYCLES(8)) dut (
        .SYS_CLK_I(clk), .RST_N_I(rst_n), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
        .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(ws),
        .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr_r), .S_AXI_BRESP_O(bresp),
        .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br), .S_AXI_ARADDR_I(ara),
        .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdata),
        .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr),
        .CHARGER_PRESENT_I(chg), .EXT_RST_N_I(ext_n), .TEST_STRAP_LOW_BIT_I(lo),
        .TEST_STRAP_HIGH_BIT_I(hi), .CHIP_RST_N_O(chip_n), .GPIO_PULL_UP_O(pu),
        .GPIO_PULL_DOWN_O(pd), .TEST_MODE_O(tm));
    cwr_far far (.clk_i(clk), .chg_o(chg), .ext_n_o(ext_n));

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic tmo_hit;
        n_errors++;
        $display("BAD t=%0t wait ran out got=%h exp=%h", $time, 0, 1);
        test_done();
    endtask
    // An edge passes first, so no strobe is set twice in one step
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int k;
        k = 0;
        @(posedge clk);
        awa <= a; awv <= 1'b1; wd <= d; wv <= 1'b1; br <= 1'b1;
        do begin
            @(posedge clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr_r) wv <= 1'b0;
            if (++k > 50) tmo_hit();
        end while (bv !== 1'b1);
        br <= 1'b0;
        chk(bresp, er);
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [1:0] er);
        int k;
        k = 0;
        @(posedge clk);
        ara <= a; arv <= 1'b1; rr <= 1'b1;
        do begin
            @(posedge clk);
            if (arv && arr) arv <= 1'b0;
            if (++k > 50) tmo_hit();
        end while (rv !== 1'b1);
        rr <= 1'b0;
        rd = rdata;
        chk(rresp, er);
    endtask
    // Status low bits against the model: enable, running, charger
    task automatic st(input int run, input int c);
        rd_reg(OFS_STATUS, RESP_OKAY);
        chk(rd & 32'h7, {29'h0, c[0], run[0], m_en[0]});
    endtask
    task automatic tmo_rd;
        rd_reg(OFS_TMO, RESP_OKAY);
        chk(rd, m_tmo);
    endtask
    task automatic wait_chip(input logic v, input int lim);
        n = 0;
        while (chip_n !== v) begin
            @(posedge clk);
            if (++n > lim) tmo_hit();
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 0; awv = 0; wv = 0; br = 0; arv = 0; rr = 0; lo = 0; hi = 0;
        awa = 0; ara = 0; wd = 0; ws = 4'hf; n_errors = 0; compares = 0;
        m_en = 0; m_tmo = WDT_TIMEOUT_MS;
        void'($urandom(32'hab09));
        repeat (8) @(posedge clk);
        chk(pu, PULL_UP_MASK);
        chk(pd, PULL_DOWN_MASK);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk(pu | pd, 0);
        st(0, 0);
        tmo_rd();
        rd_reg(4'hc, RESP_SLVERR);
        wr(4'hc, 32'h1, RESP_SLVERR);
        $display("reset test done");
        // Every strap combination, reserved wins over scan
        for (int i = 0; i < 4; i++) begin
            lo <= i[0];
            hi <= i[1];
            repeat (5) @(posedge clk);
            chk(tm, i[1] ? 2 : i);
        end
        lo <= 1'b0;
        hi <= 1'b0;
        // Enable bit without its byte lane must leave the watchdog off
        ws <= 4'he;
        wr(OFS_CTRL, 32'h1, RESP_OKAY);
        ws <= 4'hf;
        st(0, 0);
        wr(OFS_CTRL, 32'h1, RESP_OKAY);
        m_en = 1;
        wr(OFS_CTRL, 32'h0, RESP_OKAY);
        st(0, 0);
        tmo = 20 + $urandom % 8;
        m_tmo = tmo;
        wr(OFS_TMO, tmo, RESP_OKAY);
        tmo_rd();
        // Lane 1 stays off, so this timeout write must be dropped
        ws <= 4'(($urandom & 32'hd) | 32'h1);
        wr(OFS_TMO, 32'h5, RESP_OKAY);
        ws <= 4'hf;
        tmo_rd();
        // Attach starts the count; expiry resets the chip
        far.plug(1'b1);
        wait_chip(1'b0, 300);
        chk(n >= tmo * TK && n <= tmo * TK + 12, 1);
        chk(pu, PULL_UP_MASK);
        wait_chip(1'b1, 40);
        m_en = 0;
        m_tmo = WDT_TIMEOUT_MS;
        st(0, 1);
        tmo_rd();
        $display("expiry test done");
        // Enabling with charger still attached must not rearm
        wr(OFS_TMO, tmo, RESP_OKAY);
        m_tmo = tmo;
        tmo_rd();
        wr(OFS_CTRL, 32'h1, RESP_OKAY);
        m_en = 1;
        repeat (10) @(posedge clk);
        st(0, 1);
        far.plug(1'b0);
        repeat (6) @(posedge clk);
        far.plug(1'b1);
        repeat (8) @(posedge clk);
        st(1, 1);
        wr(OFS_CTRL, 32'h3, RESP_OKAY);
        st(0, 1);
        repeat (tmo * TK + 20) @(posedge clk);
        chk(chip_n, 1);
        $display("stop test done");
        // A short external low is filtered, a long one resets the chip and watchdog control
        far.ext_low(4);
        repeat (20) @(posedge clk);
        st(0, 1);
        fork
            far.ext_low(30);
            begin
                repeat (25) @(posedge clk);
                chk(chip_n, 0);
                chk(pd, PULL_DOWN_MASK);
            end
        join
        wait_chip(1'b1, 20);
        m_en = 0;
        m_tmo = WDT_TIMEOUT_MS;
        st(0, 1);
        tmo_rd();
        $display("external reset test done");
        test_done();
    end
endmodule
`default_nettype wire
